//--- core/htc_eeprom.sv
`include "htc_cfg.svh"

module htc_eeprom #(
	parameter int ROWS = `HTC_ROWS
) (
	input wire logic clock,
	htc_mem_if.mem port
);

	// ----------------------------------------
	// Cell array, kept across reset
	// ----------------------------------------
	logic [`HTC_ROW_W-1:0] cells [ROWS];
	logic [`HTC_ROW_W-1:0] rdata_reg;

	always_ff @(posedge clock) begin
		if (port.we) begin
			cells[port.addr] <= port.wdata;
		end
		rdata_reg <= cells[port.addr];
	end

	assign port.rdata = rdata_reg;

endmodule

//--- core/htc_tcomp.sv
`include "htc_cfg.svh"

module htc_tcomp (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [8:0] lin_code,
	input wire logic [7:0] quad_code,
	input wire logic [2:0] tref_code,
	input wire logic signed [7:0] die_temp,
	input wire logic signed [15:0] hall_in,
	input wire logic hall_valid,
	output logic [15:0] hall_out,
	output logic out_valid
);

	// ----------------------------------------
	// Arithmetic
	// ----------------------------------------
	// Factor in Q23: the linear step 1/65536 is 128 steps of 1/8388608
	function automatic logic signed [31:0] sens_factor(
		input logic [8:0] lin,
		input logic [7:0] quad,
		input logic [2:0] tref,
		input logic signed [7:0] temp
	);
		int ref_t;
		int d;
		int c1;
		int c2;
		ref_t = `HTC_TREF_STEP * int'(tref) - `HTC_TREF_BASE;
		d = int'(temp) - ref_t;
		c1 = int'(lin) - `HTC_LIN_OFS;
		c2 = int'(quad) - `HTC_QUAD_OFS;
		return 32'(`HTC_ONE + ((c1 * d) <<< `HTC_LIN_SHIFT) + c2 * d * d);
	endfunction

	// Clips instead of wrapping so an extreme factor cannot flip the sign
	function automatic logic [15:0] sat16(input logic signed [47:0] v);
		if (v > 48'sh7fff) begin
			return 16'h7fff;
		end else if (v < -48'sh8000) begin
			return 16'h8000;
		end
		return v[15:0];
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	htc_pkg::htc_comp_t s_reg;
	htc_pkg::htc_comp_t s_next;

	always_comb begin
		s_next = s_reg;
		s_next.valid1 = hall_valid;
		s_next.out_valid = s_reg.valid1;
		if (hall_valid) begin
			s_next.factor = sens_factor(lin_code, quad_code, tref_code, die_temp);
			s_next.hall_d = hall_in;
		end
		if (s_reg.valid1) begin
			s_next.out = sat16((48'(s_reg.hall_d) * 48'(s_reg.factor)) >>> `HTC_FRAC);
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign hall_out = s_reg.out;
	assign out_valid = s_reg.out_valid;

endmodule

//--- core/htc_top.sv
`include "htc_cfg.svh"

module htc_top #(
	parameter int CLK_HZ = `HTC_CLK_HZ,
	parameter int ERASE_CYC = int'(64'(`HTC_ERASE_PULSE_US) * 64'(CLK_HZ) / 64'd1000000),
	parameter int WRITE_CYC = int'(64'(`HTC_WRITE_PULSE_US) * 64'(CLK_HZ) / 64'd1000000)
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic signed [15:0] hall_sample,
	input wire logic hall_valid,
	input wire logic signed [7:0] die_temp,
	input wire logic prog_valid,
	input wire logic [2:0] prog_op,
	input wire logic [3:0] prog_addr,
	input wire logic [15:0] prog_wdata,
	output logic prog_ready,
	output logic [15:0] prog_rdata,
	output logic prog_rvalid,
	output logic prog_refused,
	output logic [15:0] dac_code,
	output logic dac_valid,
	output logic ee_erase_pulse,
	output logic ee_write_pulse,
	output logic mem_error,
	output logic locked,
	output logic load_done
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [3:0] col_index(input logic [`HTC_ROW_W-1:0] syn);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < `HTC_ROW_W; i++) begin
			if (syn[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	function automatic logic lock_set(input logic [`HTC_COLS-1:0] row);
		return &row[`HTC_LOCK_LSB +: 2];
	endfunction

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	htc_mem_if mem_bus ();
	htc_pkg::htc_top_t s_reg;
	htc_pkg::htc_top_t s_next;
	logic [15:0] comp_out;
	logic comp_valid;

	// 15 data rows of 9 bits, each with a row parity bit, plus one column parity row
	htc_eeprom #(
		.ROWS(`HTC_ROWS)
	) u_mem (
		.clock(clock),
		.port(mem_bus.mem)
	);

	// Coefficients always come from the shadow, never straight from cells
	htc_tcomp u_comp (
		.clock(clock),
		.sys_rst(sys_rst),
		.lin_code(s_reg.shadow[`HTC_ROW_LIN]),
		.quad_code(s_reg.shadow[`HTC_ROW_QUAD][7:0]),
		.tref_code(s_reg.shadow[`HTC_ROW_TREF][2:0]),
		.die_temp(die_temp),
		.hall_in(hall_sample),
		.hall_valid(hall_valid),
		.hall_out(comp_out),
		.out_valid(comp_valid)
	);

	assign mem_bus.addr = (s_reg.state == htc_pkg::ST_LOAD_RD) ? s_reg.idx : s_reg.cmd_addr;
	// Cell write lands on the last cycle of each pulse
	assign mem_bus.we = (s_reg.state == htc_pkg::ST_ERASE || s_reg.state == htc_pkg::ST_WRITE)
		&& s_reg.cnt == '0;
	assign mem_bus.wdata = (s_reg.state == htc_pkg::ST_WRITE) ? s_reg.cmd_data[9:0] : '0;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [`HTC_ROW_W-1:0] row;
		logic [`HTC_ROW_W-1:0] syn;
		logic [3:0] col;
		logic bad;
		row = mem_bus.rdata;
		syn = s_reg.col_acc ^ `HTC_COL_PAR_EXP;
		col = col_index(syn);
		bad = 1'b0;
		s_next = s_reg;
		s_next.prog_rvalid = 1'b0;
		s_next.prog_refused = 1'b0;
		if (hall_valid) begin
			s_next.adc_last = hall_sample;
		end
		case (s_reg.state)
			htc_pkg::ST_LOAD_RD: begin
				s_next.state = htc_pkg::ST_LOAD_CHK;
			end
			htc_pkg::ST_LOAD_CHK: begin
				if (s_reg.idx != `HTC_PAR_ROW) begin
					s_next.shadow[s_reg.idx] = row[`HTC_COLS-1:0];
				end
				s_next.col_acc = s_reg.col_acc ^ row;
				// The column parity row has no parity bit of its own: its count
				// is fixed by the other rows, so only data rows are checked
				if (s_reg.idx != `HTC_PAR_ROW && !(^row)) begin
					s_next.bad_row = s_reg.idx;
					if (s_reg.bad_cnt != 2'd2) begin
						s_next.bad_cnt = s_reg.bad_cnt + 2'd1;
					end
				end
				if (s_reg.idx == `HTC_PAR_ROW) begin
					s_next.state = htc_pkg::ST_FIX;
				end else begin
					s_next.idx = s_reg.idx + 4'd1;
					s_next.state = htc_pkg::ST_LOAD_RD;
				end
			end
			htc_pkg::ST_FIX: begin
				// Two bad rows, or syndromes that disagree, cannot be repaired
				bad = (s_reg.bad_cnt > 2'd1) || (s_reg.bad_cnt == 2'd1 && !$onehot(syn))
					// One column bit alone means only the column parity row was hit
					|| (s_reg.bad_cnt == 2'd0 && !$onehot0(syn));
				if (!bad && s_reg.bad_cnt == 2'd1 && s_reg.bad_row != `HTC_PAR_ROW
					&& col < 4'(`HTC_COLS)) begin
					s_next.shadow[s_reg.bad_row][col] = ~s_reg.shadow[s_reg.bad_row][col];
				end
				s_next.mem_error = bad;
				// Taken from the corrected row so a flipped lock bit cannot decide
				s_next.locked = lock_set(s_next.shadow[`HTC_ROW_LOCK]);
				s_next.load_done = 1'b1;
				s_next.state = htc_pkg::ST_IDLE;
			end
			htc_pkg::ST_IDLE: begin
				if (prog_valid) begin
					s_next.cmd_addr = prog_addr;
					s_next.cmd_data = prog_wdata;
					// A refusal still answers, so a programmer on shared lines is not left waiting
					if (s_reg.locked) begin
						s_next.prog_refused = 1'b1;
					end else begin
						case (htc_pkg::htc_op_t'(prog_op))
							htc_pkg::OP_RAM_WR: begin
								if (prog_addr > `HTC_LAST_DATA_ROW) begin
									s_next.prog_refused = 1'b1;
								end else begin
									s_next.shadow[prog_addr] = prog_wdata[`HTC_COLS-1:0];
									s_next.prog_rvalid = 1'b1;
									s_next.prog_rdata = prog_wdata & 16'h01ff;
								end
							end
							htc_pkg::OP_RAM_RD: begin
								if (prog_addr > `HTC_LAST_DATA_ROW) begin
									s_next.prog_refused = 1'b1;
								end else begin
									s_next.prog_rvalid = 1'b1;
									s_next.prog_rdata = {7'h00, s_reg.shadow[prog_addr]};
								end
							end
							htc_pkg::OP_EE_WR: begin
								s_next.cnt = `HTC_CNT_W'(ERASE_CYC - 1);
								s_next.state = htc_pkg::ST_ERASE;
							end
							htc_pkg::OP_EE_RD: begin
								s_next.state = htc_pkg::ST_EE_RD;
							end
							htc_pkg::OP_ADC_RD: begin
								s_next.prog_rvalid = 1'b1;
								s_next.prog_rdata = s_reg.adc_last;
							end
							htc_pkg::OP_DAC_SET: begin
								s_next.dac_test = 1'b1;
								s_next.dac_test_val = prog_wdata;
								s_next.prog_rvalid = 1'b1;
								s_next.prog_rdata = prog_wdata;
							end
							htc_pkg::OP_DAC_OFF: begin
								s_next.dac_test = 1'b0;
								s_next.prog_rvalid = 1'b1;
								s_next.prog_rdata = '0;
							end
							default: begin
								s_next.prog_rvalid = 1'b1;
								s_next.prog_rdata = {12'h000, s_reg.dac_test, s_reg.locked,
									s_reg.mem_error, s_reg.load_done};
							end
						endcase
					end
				end
			end
			htc_pkg::ST_EE_RD: begin
				s_next.state = htc_pkg::ST_EE_RET;
			end
			htc_pkg::ST_EE_RET: begin
				// Raw row with its parity bit, so the programmer can rebuild columns
				s_next.prog_rvalid = 1'b1;
				s_next.prog_rdata = {6'h00, row};
				s_next.state = htc_pkg::ST_IDLE;
			end
			htc_pkg::ST_ERASE: begin
				// Row is cleared first so the write pulse only has to set bits
				if (s_reg.cnt == '0) begin
					s_next.cnt = `HTC_CNT_W'(WRITE_CYC - 1);
					s_next.state = htc_pkg::ST_WRITE;
				end else begin
					s_next.cnt = s_reg.cnt - `HTC_CNT_W'(1);
				end
			end
			htc_pkg::ST_WRITE: begin
				if (s_reg.cnt == '0) begin
					// A locking row takes effect at once, not only after reload
					if (s_reg.cmd_addr == `HTC_ROW_LOCK && lock_set(s_reg.cmd_data[8:0])) begin
						s_next.locked = 1'b1;
					end
					s_next.prog_rvalid = 1'b1;
					s_next.prog_rdata = s_reg.cmd_data & 16'h03ff;
					s_next.state = htc_pkg::ST_IDLE;
				end else begin
					s_next.cnt = s_reg.cnt - `HTC_CNT_W'(1);
				end
			end
			default: begin
				s_next.state = htc_pkg::ST_IDLE;
			end
		endcase
		// Locking also ends any test mode so only application output remains
		if (s_next.locked) begin
			s_next.dac_test = 1'b0;
		end
		s_next.prog_ready = (s_next.state == htc_pkg::ST_IDLE);
		s_next.erase_pulse = (s_next.state == htc_pkg::ST_ERASE);
		s_next.write_pulse = (s_next.state == htc_pkg::ST_WRITE);
		// Output selection: error beats test mode, test mode beats signal path
		if (s_next.mem_error) begin
			s_next.dac_code = `HTC_DAC_SUPPLY;
			s_next.dac_valid = 1'b1;
		end else if (s_next.dac_test) begin
			s_next.dac_code = s_next.dac_test_val;
			s_next.dac_valid = 1'b1;
		end else if (s_reg.load_done && comp_valid) begin
			s_next.dac_code = comp_out;
			s_next.dac_valid = 1'b1;
		end else if (!s_reg.load_done) begin
			s_next.dac_code = `HTC_DAC_RESET;
			s_next.dac_valid = 1'b0;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		// Cells keep their contents; only the shadow and control restart
		if (sys_rst) begin
			s_reg <= '0;
			s_reg.state <= htc_pkg::ST_LOAD_RD;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prog_ready = s_reg.prog_ready;
	assign prog_rdata = s_reg.prog_rdata;
	assign prog_rvalid = s_reg.prog_rvalid;
	assign prog_refused = s_reg.prog_refused;
	assign dac_code = s_reg.dac_code;
	assign dac_valid = s_reg.dac_valid;
	assign ee_erase_pulse = s_reg.erase_pulse;
	assign ee_write_pulse = s_reg.write_pulse;
	assign mem_error = s_reg.mem_error;
	assign locked = s_reg.locked;
	assign load_done = s_reg.load_done;

endmodule

//--- pkg/htc_cfg.svh
`ifndef HTC_CFG_SVH
`define HTC_CFG_SVH

// ----------------------------------------
// Memory matrix geometry
// ----------------------------------------
`define HTC_ROWS 16
`define HTC_DATA_ROWS 15
`define HTC_COLS 9
`define HTC_ROW_W 10
`define HTC_PAR_ROW 4'hf
`define HTC_LAST_DATA_ROW 4'he
`define HTC_COL_PAR_EXP 10'h2aa

// ----------------------------------------
// Field positions in the shadow
// ----------------------------------------
`define HTC_ROW_LIN 4'h0
`define HTC_ROW_QUAD 4'h1
`define HTC_ROW_TREF 4'h2
`define HTC_ROW_LOCK 4'he
`define HTC_LOCK_LSB 7

// ----------------------------------------
// Coefficient decoding, Q23 factor
// ----------------------------------------
`define HTC_LIN_OFS 160
`define HTC_QUAD_OFS 128
`define HTC_TREF_STEP 16
`define HTC_TREF_BASE 48
`define HTC_LIN_SHIFT 7
`define HTC_FRAC 23
`define HTC_ONE 8388608

// ----------------------------------------
// Output levels and timing
// ----------------------------------------
`define HTC_DAC_SUPPLY 16'hffff
`define HTC_DAC_RESET 16'h0000
`define HTC_CLK_HZ 20000000
`define HTC_WRITE_PULSE_US 10000
`define HTC_ERASE_PULSE_US 80000
`define HTC_CNT_W 21

`endif

//--- pkg/htc_mem_if.sv
interface htc_mem_if;
	logic [3:0] addr;
	logic we;
	logic [9:0] wdata;
	logic [9:0] rdata;

	modport ctrl (output addr, output we, output wdata, input rdata);
	modport mem (input addr, input we, input wdata, output rdata);
endinterface

//--- pkg/htc_pkg.sv
`include "htc_cfg.svh"

package htc_pkg;

	typedef enum logic [3:0] {
		ST_LOAD_RD,
		ST_LOAD_CHK,
		ST_FIX,
		ST_IDLE,
		ST_EE_RD,
		ST_EE_RET,
		ST_ERASE,
		ST_WRITE
	} htc_state_t;

	typedef enum logic [2:0] {
		OP_RAM_WR,
		OP_RAM_RD,
		OP_EE_WR,
		OP_EE_RD,
		OP_ADC_RD,
		OP_DAC_SET,
		OP_DAC_OFF,
		OP_STATUS
	} htc_op_t;

	typedef struct packed {
		htc_state_t state;
		logic [3:0] idx;
		logic [`HTC_CNT_W-1:0] cnt;
		logic [`HTC_DATA_ROWS-1:0][`HTC_COLS-1:0] shadow;
		logic [`HTC_ROW_W-1:0] col_acc;
		logic [3:0] bad_row;
		logic [1:0] bad_cnt;
		logic [3:0] cmd_addr;
		logic [15:0] cmd_data;
		logic locked;
		logic mem_error;
		logic load_done;
		logic dac_test;
		logic [15:0] dac_test_val;
		logic [15:0] adc_last;
		logic [15:0] dac_code;
		logic dac_valid;
		logic prog_ready;
		logic [15:0] prog_rdata;
		logic prog_rvalid;
		logic prog_refused;
		logic erase_pulse;
		logic write_pulse;
	} htc_top_t;

	typedef struct packed {
		logic signed [31:0] factor;
		logic signed [15:0] hall_d;
		logic valid1;
		logic [15:0] out;
		logic out_valid;
	} htc_comp_t;

endpackage

//--- verification/htc_checker.sv
module htc_checker #(
	parameter int ERASE_CYC = 20,
	parameter int WRITE_CYC = 5
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic prog_valid,
	input wire logic [2:0] prog_op,
	input wire logic [3:0] prog_addr,
	input wire logic [15:0] prog_wdata,
	input wire logic prog_ready,
	input wire logic [15:0] prog_rdata,
	input wire logic prog_rvalid,
	input wire logic prog_refused,
	input wire logic [15:0] dac_code,
	input wire logic dac_valid,
	input wire logic ee_erase_pulse,
	input wire logic ee_write_pulse,
	input wire logic mem_error,
	input wire logic locked,
	input wire logic load_done
);
	// ----------------------------------------
	// Pulse length counters
	// ----------------------------------------
	logic [31:0] erase_cnt_reg;
	logic [31:0] write_cnt_reg;
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	always_ff @(posedge clock) begin
		erase_cnt_reg <= (sys_rst || !ee_erase_pulse) ? 32'h0 : erase_cnt_reg + 32'h1;
		write_cnt_reg <= (sys_rst || !ee_write_pulse) ? 32'h0 : write_cnt_reg + 32'h1;
	end
	a_erase_len: assert property ($fell(ee_erase_pulse) |-> erase_cnt_reg == ERASE_CYC)
		else $error("erase pulse length wrong");
	a_write_follows: assert property ($fell(ee_erase_pulse) |-> ee_write_pulse)
		else $error("write pulse does not follow erase");
	a_write_len: assert property ($fell(ee_write_pulse) |-> write_cnt_reg == WRITE_CYC)
		else $error("write pulse length wrong");
	a_busy_not_ready: assert property (ee_erase_pulse || ee_write_pulse |-> !prog_ready)
		else $error("ready while programming");
	a_lock_refuses: assert property (prog_valid && prog_ready && locked |=> prog_refused)
		else $error("command accepted while locked");
	a_lock_no_pulse: assert property (locked |-> !ee_erase_pulse && !ee_write_pulse)
		else $error("programming while locked");
	a_error_supply: assert property (mem_error && $past(mem_error) |-> dac_code == 16'hffff)
		else $error("error level not at supply");
	a_ram_echo: assert property (prog_valid && prog_ready && !locked && prog_op == 3'h0
		&& prog_addr != 4'hf |=> prog_rvalid && prog_rdata == ($past(prog_wdata) & 16'h01ff))
		else $error("shadow write not acknowledged");
	a_ram_top_row: assert property (prog_valid && prog_ready && prog_op == 3'h0
		&& prog_addr == 4'hf |=> prog_refused) else $error("shadow row 15 accepted");
	a_load_first: assert property (!load_done |-> !prog_ready && !dac_valid)
		else $error("active before load done");
	cover property (locked);
	cover property (mem_error);
	cover property ($fell(ee_write_pulse));
endmodule

bind htc_top htc_checker #(.ERASE_CYC(ERASE_CYC), .WRITE_CYC(WRITE_CYC)) u_chk (
	.clock(clock),
	.sys_rst(sys_rst),
	.prog_valid(prog_valid),
	.prog_op(prog_op),
	.prog_addr(prog_addr),
	.prog_wdata(prog_wdata),
	.prog_ready(prog_ready),
	.prog_rdata(prog_rdata),
	.prog_rvalid(prog_rvalid),
	.prog_refused(prog_refused),
	.dac_code(dac_code),
	.dac_valid(dac_valid),
	.ee_erase_pulse(ee_erase_pulse),
	.ee_write_pulse(ee_write_pulse),
	.mem_error(mem_error),
	.locked(locked),
	.load_done(load_done)
);

//--- verification/htc_prog_model.sv
module htc_prog_model (
	input wire logic clock,
	input wire logic prog_ready,
	input wire logic prog_rvalid,
	input wire logic prog_refused,
	output logic prog_valid,
	output logic [2:0] prog_op,
	output logic [3:0] prog_addr,
	output logic [15:0] prog_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Programmer on the command port
	// ----------------------------------------
	initial begin
		prog_valid = 1'b0;
		prog_op = 3'h0;
		prog_addr = 4'h0;
		prog_wdata = 16'h0;
	end
	// Device never makes parity, so the programmer must
	function automatic logic [9:0] row_word(input logic [8:0] d);
		return {~^d, d};
	endfunction
	// Wired straight to the port, one command at a time
	task automatic send(input logic [2:0] op, input logic [3:0] a, input logic [15:0] d);
		int n;
		@(negedge clock);
		prog_valid = 1'b1;
		prog_op = op;
		prog_addr = a;
		prog_wdata = d;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (prog_ready !== 1'b1 && n < 200);
		@(negedge clock);
		prog_valid = 1'b0;
		// Released lines never keep the old value
		prog_op = ~prog_op;
		prog_addr = ~prog_addr;
		prog_wdata = ~prog_wdata;
		for (n = 0; n < 200 && prog_rvalid !== 1'b1 && prog_refused !== 1'b1; n++)
			@(negedge clock);
	endtask
endmodule

//--- verification/test_hall_temp_comp_calib_memory.sv
module test_hall_temp_comp_calib_memory;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic refused; logic care; logic [15:0] data;} htc_exp_t;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic signed [15:0] hall_sample;
	logic hall_valid;
	logic signed [7:0] die_temp;
	logic prog_valid, prog_ready, prog_rvalid, prog_refused, dac_valid;
	logic ee_erase_pulse, ee_write_pulse, mem_error, locked, load_done;
	logic [2:0] prog_op;
	logic [3:0] prog_addr;
	logic [15:0] prog_wdata, prog_rdata, dac_code;
	htc_exp_t exp_q[$];
	int mismatches = 0;
	int checks_done = 0;
	int seed = 61;
	logic [8:0] img [15];
	always #25 clock = ~clock;
	htc_prog_model prog (.clock(clock), .prog_ready(prog_ready), .prog_rvalid(prog_rvalid),
		.prog_refused(prog_refused), .prog_valid(prog_valid), .prog_op(prog_op),
		.prog_addr(prog_addr), .prog_wdata(prog_wdata));
	htc_top #(.ERASE_CYC(20), .WRITE_CYC(5)) DUT (.clock(clock), .sys_rst(sys_rst),
		.hall_sample(hall_sample), .hall_valid(hall_valid), .die_temp(die_temp),
		.prog_valid(prog_valid), .prog_op(prog_op), .prog_addr(prog_addr),
		.prog_wdata(prog_wdata), .prog_ready(prog_ready), .prog_rdata(prog_rdata),
		.prog_rvalid(prog_rvalid), .prog_refused(prog_refused), .dac_code(dac_code),
		.dac_valid(dac_valid), .ee_erase_pulse(ee_erase_pulse),
		.ee_write_pulse(ee_write_pulse), .mem_error(mem_error), .locked(locked),
		.load_done(load_done));
	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
		checks_done++;
		if (seen !== want) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic conclude;
		if (mismatches == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(negedge clock) begin
		htc_exp_t e;
		if (prog_rvalid === 1'b1 || prog_refused === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("answer count", 16'h1, 16'h0);
			end else begin
				e = exp_q.pop_front();
				check("refused", {15'h0, prog_refused}, {15'h0, e.refused});
				if (e.care) check("rdata", prog_rdata, e.data);
			end
		end
	end
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		conclude;
	end
	task automatic cmd(input logic [2:0] op, input logic [3:0] a, input logic [15:0] d,
		input logic rf, input logic care, input logic [15:0] want);
		exp_q.push_back('{rf, care, want});
		prog.send(op, a, d);
	endtask
	task automatic do_reset;
		@(negedge clock);
		sys_rst = 1'b1;
		repeat (16) @(negedge clock);
		sys_rst = 1'b0;
		for (int n = 0; n < 100 && load_done !== 1'b1; n++) @(negedge clock);
	endtask
	// Whole image in one session; the error masks corrupt rows 3 and 5 on purpose
	task automatic program_all(input logic [9:0] e3, input logic [9:0] e5);
		logic [9:0] col, w;
		col = 10'h2aa;
		for (int r = 0; r < 15; r++) begin
			w = prog.row_word(img[r]);
			col ^= w;
			w ^= (r == 3) ? e3 : (r == 5) ? e5 : 10'h0;
			cmd(htc_pkg::OP_EE_WR, 4'(r), {6'h0, w}, 1'b0, 1'b0, 16'h0);
		end
		cmd(htc_pkg::OP_EE_WR, 4'hf, {6'h0, col}, 1'b0, 1'b0, 16'h0);
		do_reset;
	endtask
	task automatic path;
		longint h, t, d, f, p;
		h = longint'($signed(16'($random(seed))));
		t = longint'($signed(8'($random(seed))));
		d = t - 16 * longint'(img[2][2:0]) + 48;
		f = 64'sd8388608 + (((longint'(img[0]) - 160) * d) <<< 7)
			+ (longint'(img[1][7:0]) - 128) * d * d;
		p = (h * f) >>> 23;
		p = (p > 32767) ? 32767 : (p < -32768) ? -32768 : p;
		@(negedge clock);
		hall_sample = h[15:0];
		die_temp = t[7:0];
		hall_valid = 1'b1;
		@(negedge clock);
		hall_valid = 1'b0;
		repeat (3) @(negedge clock);
		check("hall out", dac_code, p[15:0]);
		cmd(htc_pkg::OP_ADC_RD, 4'h0, 16'h0, 1'b0, 1'b1, h[15:0]);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		hall_sample = 16'h0;
		hall_valid = 1'b0;
		die_temp = 8'h0;
		for (int r = 0; r < 15; r++) img[r] = 9'($random(seed));
		img[14][8:7] = 2'b00;
		do_reset;
		// Four sessions in the run, inside the endurance budget
		program_all(10'h0, 10'h0);
		check("flags", {13'h0, load_done, locked, mem_error}, 16'h0004);
		for (int r = 0; r < 3; r++)
			cmd(htc_pkg::OP_RAM_RD, 4'(r), 16'h0, 1'b0, 1'b1, {7'h0, img[r]});
		cmd(htc_pkg::OP_EE_RD, 4'h2, 16'h0, 1'b0, 1'b1, {6'h0, prog.row_word(img[2])});
		path;
		// New coefficients tried in the shadow only
		for (int r = 0; r < 3; r++) begin
			img[r] = 9'($random(seed));
			cmd(htc_pkg::OP_RAM_WR, 4'(r), {7'h0, img[r]}, 1'b0, 1'b1, {7'h0, img[r]});
		end
		repeat (3) path;
		cmd(htc_pkg::OP_RAM_WR, 4'hf, 16'h0, 1'b1, 1'b0, 16'h0);
		cmd(htc_pkg::OP_DAC_SET, 4'h0, 16'h5a3c, 1'b0, 1'b1, 16'h5a3c);
		check("dac test", dac_code, 16'h5a3c);
		cmd(htc_pkg::OP_DAC_OFF, 4'h0, 16'h0, 1'b0, 1'b0, 16'h0);
		cmd(htc_pkg::OP_STATUS, 4'h0, 16'h0, 1'b0, 1'b1, 16'h0001);
		program_all(10'h010, 10'h0);
		cmd(htc_pkg::OP_RAM_RD, 4'h3, 16'h0, 1'b0, 1'b1, {7'h0, img[3]});
		check("single error", {15'h0, mem_error}, 16'h0);
		path;
		program_all(10'h010, 10'h100);
		check("double error", {15'h0, mem_error}, 16'h1);
		check("error level", dac_code, 16'hffff);
		program_all(10'h0, 10'h0);
		img[14][8:7] = 2'b11;
		cmd(htc_pkg::OP_EE_WR, 4'he, {6'h0, prog.row_word(img[14])}, 1'b0, 1'b0, 16'h0);
		check("locked", {15'h0, locked}, 16'h1);
		cmd(htc_pkg::OP_RAM_WR, 4'h0, 16'h0, 1'b1, 1'b0, 16'h0);
		cmd(htc_pkg::OP_EE_WR, 4'h0, 16'h0, 1'b1, 1'b0, 16'h0);
		conclude;
	end
endmodule
